/* File: verilog/gpdef_pkg.sv */
package gpdef_pkg;
    localparam logic [3:0] OFS_D_LATCH = 4'h3;
    localparam logic [3:0] OFS_E_LATCH = 4'h8;
    localparam logic [3:0] OFS_F_LATCH = 4'h9;
    localparam logic [3:0] OFS_D_DIR = 4'h4;
    localparam logic [3:0] OFS_E_DIR = 4'hc;
    localparam logic [3:0] OFS_F_DIR = 4'hd;
    localparam logic [3:0] OFS_PERIPH_CTRL = 4'he;
    localparam logic [7:0] DIR_D_RESET = 8'h00;
    localparam logic [7:0] DIR_E_RESET = 8'h00;
    localparam logic [6:0] DIR_F_RESET = 7'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] PRESCALE_EXT_CLK = 3'h7;
    localparam int BIT_TAKE_SPE = 0;
    localparam int BIT_TAKE_MSTR = 1;
    localparam int BIT_TAKE_MODF = 2;
    localparam int BIT_TAKE_UART = 3;
    localparam int PIN_TIMER_CLK = 6;
    localparam int PIN_SS = 4;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gpdef_bus_t;

    typedef struct packed {
        logic [7:0] d;
        logic [7:0] e;
        logic [6:0] f;
    } gpdef_pins_t;
endpackage

/* File: verilog/gpdef_ports.sv */
`timescale 1ns/10ps
module gpdef_ports
    import gpdef_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [3:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    output logic [7:0] busRdata,
    input wire logic [7:0] padDIn,
    input wire logic [7:0] padEIn,
    input wire logic [6:0] padFIn,
    output logic [7:0] padDOut,
    output logic [7:0] padDOe,
    output logic [7:0] padEOut,
    output logic [7:0] padEOe,
    output logic [6:0] padFOut,
    output logic [6:0] padFOe,
    input wire logic [7:0] adcClaimD,
    input wire logic [2:0] prescaler_select,
    input wire logic [1:0] edge_level_select_high,
    input wire logic [1:0] edge_level_select_low,
    input wire logic [3:0] timerClaimF,
    input wire logic [5:0] timerChOut,
    input wire logic [5:0] timerChOe,
    input wire logic spiClkOut,
    input wire logic spiMosiOut,
    input wire logic spiMisoOut,
    input wire logic uartTxOut,
    output logic timer_external_clock_in,
    output logic [5:0] timerChIn,
    output logic spiClkIn,
    output logic spiMosiIn,
    output logic spiMisoIn,
    output logic spiSsIn,
    output logic uartRxIn,
    output logic serial_periph_enable,
    output logic serial_periph_master,
    output logic mode_fault_enable,
    output logic uart_enable
);
    gpdef_bus_t bus;
    gpdef_pins_t syncA_r, syncB_r;
    logic [7:0] port_d_latch_r, port_e_latch_r;
    logic [6:0] port_f_latch_r;
    logic [7:0] port_d_direction_r, port_e_direction_r;
    logic [6:0] port_f_direction_r;
    logic [7:0] ctrl_r, rdata_nxt;
    logic [7:0] dOut_r, dOe_r, eOut_r, eOe_r;
    logic [6:0] fOut_r, fOe_r;
    logic [6:0] tIn_r;
    logic [4:0] sIn_r;

    assign bus = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};

    wire spiOn = ctrl_r[BIT_TAKE_SPE];
    wire spiMaster = ctrl_r[BIT_TAKE_MSTR];
    wire ssUsed = spiOn && !(spiMaster && !ctrl_r[BIT_TAKE_MODF]);
    wire uartOn = ctrl_r[BIT_TAKE_UART];
    wire [1:0] chOn = edge_level_select_high | edge_level_select_low;
    wire extClk = (prescaler_select == PRESCALE_EXT_CLK);

    // claim masks per port
    wire [7:0] claimE = {{3{spiOn}}, ssUsed, chOn, {2{uartOn}}};
    wire [7:0] claimD = adcClaimD;

    // peripheral drive for claimed port E pins; slave side inputs are not driven
    wire [7:0] perEOut = {spiClkOut, spiMosiOut, spiMisoOut, 1'b0,
                          timerChOut[1:0], 1'b0, uartTxOut};
    wire [7:0] perEOe = {spiMaster, spiMaster, !spiMaster, 1'b0,
                         timerChOe[1:0], 1'b0, 1'b1};

    // next pin drive: claimed pins ignore the direction bits
    wire [7:0] dOeNxt = port_d_direction_r & ~claimD;
    wire [7:0] eOeNxt = (port_e_direction_r & ~claimE) | (perEOe & claimE);
    wire [7:0] eOutNxt = (port_e_latch_r & ~claimE) | (perEOut & claimE);
    wire [3:0] fClaim = timerClaimF;
    wire [6:0] fOeNxt = (port_f_direction_r & ~{3'h0, fClaim})
                      | ({3'h0, timerChOe[5:2]} & {3'h0, fClaim});
    wire [6:0] fOutNxt = (port_f_latch_r & ~{3'h0, fClaim})
                       | ({3'h0, timerChOut[5:2]} & {3'h0, fClaim});

    // read values: the direction bit still picks latch against pin
    wire [7:0] dPinRd = syncB_r.d & ~claimD;
    wire [7:0] dRead = (port_d_direction_r & port_d_latch_r)
                     | (~port_d_direction_r & dPinRd);
    wire [7:0] eRead = (port_e_direction_r & port_e_latch_r)
                     | (~port_e_direction_r & syncB_r.e);
    wire [6:0] fRead = (port_f_direction_r & port_f_latch_r)
                     | (~port_f_direction_r & syncB_r.f);

    always_comb begin
        case (bus.addr)
            OFS_D_LATCH: rdata_nxt = dRead;
            OFS_E_LATCH: rdata_nxt = eRead;
            OFS_F_LATCH: rdata_nxt = {1'b0, fRead};
            OFS_D_DIR: rdata_nxt = port_d_direction_r;
            OFS_E_DIR: rdata_nxt = port_e_direction_r;
            OFS_F_DIR: rdata_nxt = {1'b0, port_f_direction_r};
            OFS_PERIPH_CTRL: rdata_nxt = {4'h0, ctrl_r[3:0]};
            default: rdata_nxt = 8'h00;
        endcase
    end

    // pins are asynchronous to mclk, so only the second stage is ever read
    always_ff @(posedge mclk) begin
        syncA_r <= '{d: padDIn, e: padEIn, f: padFIn};
        syncB_r <= syncA_r;
    end

    // data latches carry no reset and accept writes in any direction
    always_ff @(posedge mclk) begin
        if (bus.wr && bus.addr == OFS_D_LATCH) begin
            port_d_latch_r <= bus.wdata;
        end
        if (bus.wr && bus.addr == OFS_E_LATCH) begin
            port_e_latch_r <= bus.wdata;
        end
        if (bus.wr && bus.addr == OFS_F_LATCH) begin
            port_f_latch_r <= bus.wdata[6:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            port_d_direction_r <= DIR_D_RESET;
            port_e_direction_r <= DIR_E_RESET;
            port_f_direction_r <= DIR_F_RESET;
            ctrl_r <= CTRL_RESET;
        end else if (bus.wr) begin
            if (bus.addr == OFS_D_DIR) begin
                port_d_direction_r <= bus.wdata;
            end
            if (bus.addr == OFS_E_DIR) begin
                port_e_direction_r <= bus.wdata;
            end
            if (bus.addr == OFS_F_DIR) begin
                port_f_direction_r <= bus.wdata[6:0];
            end
            if (bus.addr == OFS_PERIPH_CTRL) begin
                ctrl_r <= {4'h0, bus.wdata[3:0]};
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (reset) begin
            busRdata <= 8'h00;
        end else begin
            busRdata <= bus.rd ? rdata_nxt : 8'h00;
        end
    end

    // registered pad drive; latches are unknown after power-up until written
    always_ff @(posedge mclk) begin
        if (reset) begin
            dOut_r <= 8'h00;
            dOe_r <= 8'h00;
            eOut_r <= 8'h00;
            eOe_r <= 8'h00;
            fOut_r <= 7'h00;
            fOe_r <= 7'h00;
        end else begin
            dOut_r <= port_d_latch_r;
            dOe_r <= dOeNxt;
            eOut_r <= eOutNxt;
            eOe_r <= eOeNxt;
            fOut_r <= fOutNxt;
            fOe_r <= fOeNxt;
        end
    end

    // peripheral inputs from synchronised pins
    always_ff @(posedge mclk) begin
        if (reset) begin
            tIn_r <= 7'h00;
            sIn_r <= 5'h00;
        end else begin
            tIn_r <= {extClk & syncB_r.d[PIN_TIMER_CLK], syncB_r.f[3:0],
                      syncB_r.e[3:2] & chOn};
            sIn_r <= {syncB_r.e[7:5] & {3{spiOn}},
                      ssUsed ? syncB_r.e[PIN_SS] : 1'b1,
                      uartOn ? syncB_r.e[1] : 1'b1};
        end
    end

    assign padDOut = dOut_r;
    assign padDOe = dOe_r;
    assign padEOut = eOut_r;
    assign padEOe = eOe_r;
    assign padFOut = fOut_r;
    assign padFOe = fOe_r;
    assign timer_external_clock_in = tIn_r[6];
    assign timerChIn = tIn_r[5:0];
    assign spiClkIn = sIn_r[4];
    assign spiMosiIn = sIn_r[3];
    assign spiMisoIn = sIn_r[2];
    assign spiSsIn = sIn_r[1];
    assign uartRxIn = sIn_r[0];
    assign serial_periph_enable = ctrl_r[BIT_TAKE_SPE];
    assign serial_periph_master = ctrl_r[BIT_TAKE_MSTR];
    assign mode_fault_enable = ctrl_r[BIT_TAKE_MODF];
    assign uart_enable = ctrl_r[BIT_TAKE_UART];
endmodule

/* File: test/gpdef_pin_model.sv */
`timescale 1ns/10ps
module gpdef_pin_model
    import gpdef_pkg::*;
(
    input wire gpdef_pins_t pinOut,
    input wire gpdef_pins_t pinOe,
    input wire gpdef_pins_t ext,
    output gpdef_pins_t pinIn
);
    // a driven pin reads back its driver, a released one shows the outside level
    assign pinIn = (pinOe & pinOut) | (~pinOe & ext);
endmodule

/* File: test/gpdef_ports_sva.sv */
`timescale 1ns/10ps
module gpdef_sva
    import gpdef_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [3:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    input wire logic [7:0] busRdata,
    input wire logic [7:0] padDIn,
    input wire logic [7:0] padDOut,
    input wire logic [7:0] padDOe,
    input wire logic [7:0] padEOe,
    input wire logic [6:0] padFOe,
    input wire logic [7:0] adcClaimD,
    input wire logic [2:0] prescaler_select,
    input wire logic timer_external_clock_in,
    input wire logic serial_periph_enable,
    input wire logic serial_periph_master,
    input wire logic uart_enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    property p_rst; disable iff (1'b0) reset |=> !padDOe && !padEOe && !padFOe; endproperty
    a_rst: assert property (p_rst) else $error("oe not cleared");
    property p_f7;
        busRd && (busAddr == OFS_F_LATCH || busAddr == OFS_F_DIR) |=> !busRdata[7];
    endproperty
    a_f7: assert property (p_f7) else $error("port f bit 7 set");
    property p_pin;
        ($stable(padDIn) && !padDOe && !adcClaimD && !busWr)[*3] ##0
        busRd && busAddr == OFS_D_LATCH |=> busRdata == $past(padDIn);
    endproperty
    a_pin: assert property (p_pin) else $error("pin read wrong");
    property p_lat;
        (!busWr && (&padDOe))[*2] ##0 busRd && busAddr == OFS_D_LATCH
        |=> busRdata == padDOut;
    endproperty
    a_lat: assert property (p_lat) else $error("latch read wrong");
    property p_doe;
        busWr && busAddr == OFS_D_DIR ##1 $stable(adcClaimD)
        |=> padDOe == ($past(busWdata, 2) & ~$past(adcClaimD));
    endproperty
    a_doe: assert property (p_doe) else $error("d drive wrong");
    property p_clk; (prescaler_select == PRESCALE_EXT_CLK && $stable(padDIn[6]))[*4] |-> timer_external_clock_in == padDIn[6]; endproperty
    a_clk: assert property (p_clk) else $error("timer clock wrong");
    property p_slv; (serial_periph_enable && !serial_periph_master)[*2] |-> padEOe[5:4] == 2'b10; endproperty
    a_slv: assert property (p_slv) else $error("slave pins wrong");
    property p_uart; uart_enable[*2] |-> padEOe[1:0] == 2'b01; endproperty
    a_uart: assert property (p_uart) else $error("uart pins wrong");
    c_rd: cover property (busRd && busAddr == OFS_D_LATCH);
    c_slv: cover property (serial_periph_enable && !serial_periph_master);
    c_uart: cover property (uart_enable);
endmodule

/* File: test/gpdef_ports_bench.sv */
`timescale 1ns/10ps
module gpdef_ports_bench;
    import gpdef_pkg::*;
    logic mclk, reset, busWr, busRd, spiClkOut, spiMosiOut, spiMisoOut, uartTxOut;
    logic [3:0] busAddr, timerClaimF;
    logic [7:0] busWdata, adcClaimD, extD, extE;
    logic [6:0] extF;
    logic [2:0] prescaler_select;
    logic [1:0] edge_level_select_high, edge_level_select_low;
    logic [5:0] timerChOut, timerChOe;
    wire [7:0] busRdata, padDIn, padEIn, padDOut, padDOe, padEOut, padEOe;
    wire [6:0] padFIn, padFOut, padFOe;
    wire timer_external_clock_in;
    int n_fail, checked;
    gpdef_ports gpdef_ports_i(.mclk, .reset, .busAddr, .busWdata, .busWr, .busRd, .busRdata,
        .padDIn, .padEIn, .padFIn, .padDOut, .padDOe, .padEOut, .padEOe, .padFOut, .padFOe,
        .adcClaimD, .prescaler_select, .edge_level_select_high, .edge_level_select_low,
        .timerClaimF, .timerChOut, .timerChOe, .spiClkOut, .spiMosiOut, .spiMisoOut,
        .uartTxOut, .timer_external_clock_in, .timerChIn(), .spiClkIn(), .spiMosiIn(),
        .spiMisoIn(), .spiSsIn(), .uartRxIn(), .serial_periph_enable(),
        .serial_periph_master(), .mode_fault_enable(), .uart_enable());
    gpdef_pin_model gpdef_pin_model_i(.pinOut({padDOut, padEOut, padFOut}),
        .pinOe({padDOe, padEOe, padFOe}), .ext({extD, extE, extF}),
        .pinIn({padDIn, padEIn, padFIn}));
    task automatic chk(input string nm, input logic [7:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    // strobes drop for a cycle so no signal is assigned twice in one step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        busAddr <= a;
        busWdata <= d;
        busWr <= 1'b1;
        @(posedge mclk);
        busWr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge mclk);
        busRd <= 1'b0;
        #1 chk($sformatf("rd %h", a), busRdata, exp);
        @(posedge mclk);
    endtask
    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic rst;
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        repeat (3000) @(posedge mclk);
        n_fail++;
        summarize();
    end
    initial begin
        {busWr, busRd, spiClkOut, spiMosiOut, spiMisoOut, uartTxOut} = 6'h00;
        {busAddr, busWdata, timerClaimF, timerChOut, timerChOe} = 28'h0;
        {prescaler_select, edge_level_select_high, edge_level_select_low} = 7'h00;
        {adcClaimD, extD, extE, extF} = {8'h00, 8'h3c, 8'ha5, 7'h55};
        rst();
        rd(OFS_D_DIR, 8'h00);
        rd(OFS_E_DIR, 8'h00);
        rd(OFS_F_DIR, 8'h00);
        rd(OFS_D_LATCH, 8'h3c);
        rd(OFS_E_LATCH, 8'ha5);
        rd(OFS_F_LATCH, 8'h55);
        rd(4'h0, 8'h00);
        wr(OFS_D_LATCH, 8'h5a); // latch first, then direction
        rd(OFS_D_LATCH, 8'h3c);
        wr(OFS_D_DIR, 8'hf0);
        settle();
        chk("d oe", padDOe, 8'hf0);
        rd(OFS_D_LATCH, 8'h5c);
        adcClaimD <= 8'h14;
        settle();
        chk("d oe claim", padDOe, 8'he0);
        rd(OFS_D_LATCH, 8'h58);
        adcClaimD <= 8'h00;
        wr(OFS_D_DIR, 8'hff);
        settle();
        chk("d out", padDOut, 8'h5a);
        rd(OFS_D_LATCH, 8'h5a);
        wr(OFS_F_DIR, 8'hff);
        rd(OFS_F_DIR, 8'h7f);
        wr(OFS_F_LATCH, 8'h2a);
        rst();
        wr(OFS_F_DIR, 8'h7f);
        settle();
        chk("f oe", {1'b0, padFOe}, 8'h7f);
        rd(OFS_F_LATCH, 8'h2a);
        wr(OFS_PERIPH_CTRL, 8'h01);
        wr(OFS_E_DIR, 8'hff);
        settle();
        chk("e oe slave", padEOe, 8'h2f);
        wr(OFS_PERIPH_CTRL, 8'h03);
        settle();
        chk("e oe master", padEOe, 8'hdf);
        wr(OFS_PERIPH_CTRL, 8'h07);
        settle();
        chk("e oe modf", padEOe, 8'hcf);
        rd(OFS_PERIPH_CTRL, 8'h07);
        wr(OFS_PERIPH_CTRL, 8'h08);
        wr(OFS_E_DIR, 8'h00);
        settle();
        chk("e oe uart", padEOe, 8'h01);
        edge_level_select_low <= 2'b01;
        edge_level_select_high <= 2'b10;
        {timerClaimF, timerChOe} <= {4'h1, 6'h06};
        wr(OFS_PERIPH_CTRL, 8'h00);
        wr(OFS_E_DIR, 8'hff);
        wr(OFS_F_DIR, 8'h00);
        settle();
        chk("e oe timer", padEOe, 8'hfb);
        chk("f oe timer", {1'b0, padFOe}, 8'h01);
        prescaler_select <= PRESCALE_EXT_CLK; // no converter claim meanwhile
        extD <= 8'h40;
        settle();
        chk("timer clock", {7'h00, timer_external_clock_in}, 8'h01);
        summarize();
    end
endmodule
bind gpdef_ports gpdef_sva gpdef_sva_i(.mclk, .reset, .busAddr, .busWdata, .busWr, .busRd,
    .busRdata, .padDIn, .padDOut, .padDOe, .padEOe, .padFOe, .adcClaimD, .prescaler_select,
    .timer_external_clock_in, .serial_periph_enable, .serial_periph_master, .uart_enable);
